// File: src/csm_pkg.sv
package csm_pkg;
    localparam logic [7:0] ADDR_CUR_HI = 8'h00;
    localparam logic [7:0] ADDR_CUR_LO = 8'h01;
    localparam logic [7:0] ADDR_WARN_HI = 8'h22;
    localparam logic [7:0] ADDR_WARN_LO = 8'h23;
    localparam logic [7:0] ADDR_FAST_DAC = 8'h2E;
    localparam logic [7:0] ADDR_RATIO = 8'h30;
    localparam logic [7:0] ADDR_RANGE = 8'h33;

    localparam logic [7:0] RST_CUR_HI = 8'h00;
    localparam logic [1:0] RST_CUR_LO = 2'h0;
    localparam logic [7:0] RST_WARN_HI = 8'hFF;
    localparam logic [1:0] RST_WARN_LO = 2'h3;
    localparam logic [7:0] RST_FAST_DAC = 8'hBF;
    localparam logic [3:0] RST_RATIO = 4'hF;
    localparam logic [3:0] RST_RANGE = 4'h0;

    // Range field codes (full scale 25, 50, 100 mV)
    localparam logic [1:0] RANGE_25MV = 2'h2;
    localparam logic [1:0] RANGE_50MV = 2'h1;
    localparam logic [1:0] RANGE_100MV = 2'h0;

    // Fast-to-slow ratio codes: 125, 150, 175, 200 percent
    localparam logic [1:0] RATIO_125 = 2'h0;
    localparam logic [1:0] RATIO_150 = 2'h1;
    localparam logic [1:0] RATIO_175 = 2'h2;
    localparam logic [1:0] RATIO_200 = 2'h3;

    localparam int SPLIT_LO_BITS = 2;
    localparam int SAMPLE_WIDTH = 10;
    localparam int CLK_HZ = 125_000_000;
    localparam int SAMPLE_RATE_HZ = 10_000;
    localparam int SAMPLE_CYCLES = CLK_HZ / SAMPLE_RATE_HZ;
endpackage

// File: src/csm_top.sv
`timescale 1ns/1ps
// Summary of operation
// R1: 2-bit range field, upper bits fixed read-only; here bits 3:2 are writable, only bits 7:4 read zero
// R2: Pin low 10, high 01, open 00
// R3: Range loaded from pin at power-up, rewritable
// R4: Fast DAC register 0x2E, resets 0xBF
// R5: Fast-trip range follows selected current range; not modeled, fast_dac_code is the DAC register alone
// R6: Ratio code 00..11 is 125..200 percent
// R7: Sample current at 10 ksps, keep latest
// R8: Result bits 9:2 low address, 1:0 next
// R9: Same split storage for thresholds too
// R10: Compare samples only while power good
// R11: Sample above threshold asserts alert
// R12: Warning response ignores protection pin
// R13: Warning threshold at 0x22/0x23, resets FF/03
// R14: Full 10-bit compare, strictly greater only
module csm_top #(
    parameter int SAMPLE_CYCLES = csm_pkg::SAMPLE_CYCLES
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic range_select_pin_driven,
    input wire logic range_select_pin_level,
    input wire logic power_good_out,
    input wire logic protection_behaviour_pin,
    input wire logic [9:0] adc_data,
    output logic adc_sample_tick,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic [7:0] fast_dac_code,
    output logic [1:0] trip_ratio_setting,
    output logic [1:0] range_field,
    output logic alert_out
);
    logic [15:0] div_reg, div_next;
    logic [9:0] cur_reg, cur_next;
    logic [9:0] warn_reg, warn_next;
    logic [7:0] dac_reg, dac_next;
    logic [3:0] ratio_reg, ratio_next;
    logic [3:0] range_reg, range_next;
    logic loaded_reg, loaded_next;
    logic alert_reg, alert_next;
    logic [7:0] rdata_reg, rdata_next;
    logic tick;
    logic behaviour_level;

    // Three-state pin decode into the range code
    function automatic logic [1:0] pin_to_range(input logic driven,
                                                input logic level);
        if (!driven) begin
            pin_to_range = csm_pkg::RANGE_100MV; // [R2]
        end else if (level) begin
            pin_to_range = csm_pkg::RANGE_50MV; // [R2]
        end else begin
            pin_to_range = csm_pkg::RANGE_25MV; // [R2]
        end
    endfunction

    // Divider stands in for the converter's conversion rate
    assign tick = (div_reg == 16'(SAMPLE_CYCLES - 1));
    // The protection pin has no say over the warning path
    assign behaviour_level = protection_behaviour_pin; // [R12]

    always_comb begin
        div_next = tick ? 16'h0000 : div_reg + 16'h0001; // [R7]
        cur_next = tick ? adc_data : cur_reg; // [R7]
        warn_next = warn_reg;
        dac_next = dac_reg;
        ratio_next = ratio_reg;
        range_next = range_reg;
        loaded_next = 1'b1;
        if (!loaded_reg) begin
            // Strap is caught on the first edge after reset release
            range_next = {2'h0, pin_to_range(range_select_pin_driven,
                                            range_select_pin_level)}; // [R3]
        end else if (reg_wr) begin
            case (reg_addr)
                csm_pkg::ADDR_WARN_HI: warn_next[9:2] = reg_wdata; // [R13]
                csm_pkg::ADDR_WARN_LO: warn_next[1:0] = reg_wdata[1:0]; // [R9]
                csm_pkg::ADDR_FAST_DAC: dac_next = reg_wdata; // [R4] [R5]
                csm_pkg::ADDR_RATIO: ratio_next = reg_wdata[3:0]; // [R6]
                csm_pkg::ADDR_RANGE: range_next = reg_wdata[3:0]; // [R3]
                default: ;
            endcase
        end
        // Level alert follows the latest sample; forced low while not power good
        alert_next = alert_reg;
        if (!power_good_out) begin
            alert_next = 1'b0; // [R10]
        end else if (tick) begin
            alert_next = (adc_data > warn_reg); // [R11] [R14]
        end
        // Unmapped reads return zero; reg_rdata holds between reads
        rdata_next = rdata_reg;
        if (reg_rd) begin
            case (reg_addr)
                csm_pkg::ADDR_CUR_HI: rdata_next = cur_reg[9:2]; // [R8]
                csm_pkg::ADDR_CUR_LO: begin // [R8]
                    rdata_next = {6'h00, cur_reg[1:0]};
                end
                csm_pkg::ADDR_WARN_HI: rdata_next = warn_reg[9:2];
                csm_pkg::ADDR_WARN_LO: rdata_next = {6'h00, warn_reg[1:0]};
                csm_pkg::ADDR_FAST_DAC: rdata_next = dac_reg;
                csm_pkg::ADDR_RATIO: rdata_next = {4'h0, ratio_reg};
                csm_pkg::ADDR_RANGE: rdata_next = {4'h0, range_reg}; // [R1]
                default: rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            div_reg <= 16'h0000;
            cur_reg <= {csm_pkg::RST_CUR_HI, csm_pkg::RST_CUR_LO};
            warn_reg <= {csm_pkg::RST_WARN_HI, csm_pkg::RST_WARN_LO}; // [R13]
            dac_reg <= csm_pkg::RST_FAST_DAC; // [R4]
            ratio_reg <= csm_pkg::RST_RATIO; // [R6]
            range_reg <= csm_pkg::RST_RANGE;
            loaded_reg <= 1'b0;
            alert_reg <= 1'b0;
            rdata_reg <= 8'h00;
        end else begin
            div_reg <= div_next;
            cur_reg <= cur_next;
            warn_reg <= warn_next;
            dac_reg <= dac_next;
            ratio_reg <= ratio_next;
            range_reg <= range_next;
            loaded_reg <= loaded_next;
            alert_reg <= alert_next;
            rdata_reg <= rdata_next;
        end
    end

    assign adc_sample_tick = tick;
    assign reg_rdata = rdata_reg;
    assign fast_dac_code = dac_reg;
    assign trip_ratio_setting = ratio_reg[1:0];
    assign range_field = range_reg[1:0];
    assign alert_out = alert_reg;

    // Strap check one edge after the field was loaded
    range_strap_a: assert property ( // [R3]
        @(posedge clk_sys) disable iff (sys_rst)
        loaded_reg && !$past(loaded_reg) |->
        range_reg[1:0] == pin_to_range($past(range_select_pin_driven),
                                       $past(range_select_pin_level)))
        else $error("range not loaded from pin");
    range_upper_a: assert property ( // [R1]
        @(posedge clk_sys) disable iff (sys_rst)
        reg_rd && reg_addr == csm_pkg::ADDR_RANGE |=>
        reg_rdata[7:4] == 4'h0)
        else $error("range upper bits not zero");
    range_code_a: assert property ( // [R2]
        @(posedge clk_sys) disable iff (sys_rst)
        !loaded_reg && !range_select_pin_driven |=>
        range_field == csm_pkg::RANGE_100MV)
        else $error("open pin not 100 mV code");
    range_write_a: assert property ( // [R3]
        @(posedge clk_sys) disable iff (sys_rst)
        loaded_reg && reg_wr && reg_addr == csm_pkg::ADDR_RANGE |=>
        range_field == $past(reg_wdata[1:0]))
        else $error("range write lost");

    dac_write_a: assert property ( // [R4]
        @(posedge clk_sys) disable iff (sys_rst)
        loaded_reg && reg_wr && reg_addr == csm_pkg::ADDR_FAST_DAC |=>
        fast_dac_code == $past(reg_wdata))
        else $error("dac write lost");
    ratio_write_a: assert property ( // [R6]
        @(posedge clk_sys) disable iff (sys_rst)
        loaded_reg && reg_wr && reg_addr == csm_pkg::ADDR_RATIO |=>
        trip_ratio_setting == $past(reg_wdata[1:0]))
        else $error("ratio write lost");
    warn_hi_a: assert property ( // [R13]
        @(posedge clk_sys) disable iff (sys_rst)
        loaded_reg && reg_wr && reg_addr == csm_pkg::ADDR_WARN_HI |=>
        warn_reg[9:2] == $past(reg_wdata))
        else $error("threshold high bits wrong");
    warn_split_a: assert property ( // [R9]
        @(posedge clk_sys) disable iff (sys_rst)
        loaded_reg && reg_wr && reg_addr == csm_pkg::ADDR_WARN_LO |=>
        warn_reg[1:0] == $past(reg_wdata[1:0]))
        else $error("threshold low bits wrong");

    // Captures and reads take the value held at the tick or read edge
    sample_period_a: assert property ( // [R7]
        @(posedge clk_sys) disable iff (sys_rst)
        tick |=>
        !tick && cur_reg == $past(adc_data))
        else $error("sample not captured");
    split_hi_a: assert property ( // [R8]
        @(posedge clk_sys) disable iff (sys_rst)
        reg_rd && reg_addr == csm_pkg::ADDR_CUR_HI |=>
        reg_rdata == $past(cur_reg[9:2]))
        else $error("high result bits wrong");
    split_read_a: assert property ( // [R8]
        @(posedge clk_sys) disable iff (sys_rst)
        reg_rd && reg_addr == csm_pkg::ADDR_CUR_LO |=>
        reg_rdata == {6'h00, $past(cur_reg[1:0])})
        else $error("low result bits wrong");

    pwr_gate_a: assert property ( // [R10]
        @(posedge clk_sys) disable iff (sys_rst)
        !power_good_out |=>
        !alert_out)
        else $error("alert without power good");
    alert_set_a: assert property ( // [R11]
        @(posedge clk_sys) disable iff (sys_rst)
        power_good_out && tick && adc_data > warn_reg |=>
        alert_out)
        else $error("alert missed");
    strict_cmp_a: assert property ( // [R14]
        @(posedge clk_sys) disable iff (sys_rst)
        power_good_out && tick && adc_data == warn_reg |=>
        !alert_out)
        else $error("alert on equal value");
    // Protection pin high must leave the compare result untouched
    warn_behav_a: assert property ( // [R12]
        @(posedge clk_sys) disable iff (sys_rst)
        power_good_out && tick && behaviour_level |=>
        alert_out == ($past(adc_data) > $past(warn_reg)))
        else $error("alert altered by protection pin");
endmodule // csm_top

// File: dv/csm_host.sv
`timescale 1ns/1ps
// Byte register host; released lines carry the inverse of the last value
module csm_host (
    input wire logic clk_sys,
    input wire logic [7:0] reg_rdata,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd
);
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~v;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        #1;
        v = reg_rdata;
    endtask
endmodule // csm_host

// File: dv/tb.sv
`timescale 1ns/1ps
module tb;
    logic clk_sys, sys_rst, drv, lvl, pwr_ok, behav_pin, wr, rd, tick, alert;
    logic [9:0] adc;
    logic [7:0] addr, wdata, rdata, dac;
    logic [1:0] ratio, rng;
    logic [1:0] exp_rng [3] = '{2'h2, 2'h1, 2'h0};
    int n_errors = 0;
    int check_count = 0;
    localparam int SIM_CYCLES = 8;
    csm_top #(.SAMPLE_CYCLES(SIM_CYCLES)) i_dut (.clk_sys(clk_sys),
        .sys_rst(sys_rst), .range_select_pin_driven(drv),
        .range_select_pin_level(lvl), .power_good_out(pwr_ok),
        .protection_behaviour_pin(behav_pin), .adc_data(adc),
        .adc_sample_tick(tick), .reg_addr(addr), .reg_wdata(wdata),
        .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .fast_dac_code(dac),
        .trip_ratio_setting(ratio), .range_field(rng), .alert_out(alert));
    csm_host i_host (.clk_sys(clk_sys), .reg_rdata(rdata), .reg_addr(addr),
        .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd));
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] want);
        check_count++;
        if (got !== want) begin
            n_errors++;
            $display("BAD %0t got %h want %h", $time, got, want);
        end
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] want);
        logic [7:0] v;
        i_host.rd(a, v);
        chk(v, want);
    endtask
    task automatic rst(input logic d, input logic l);
        @(posedge clk_sys);
        sys_rst <= 1'b1;
        drv <= d;
        lvl <= l;
        repeat (4) @(posedge clk_sys);
        sys_rst <= 1'b0;
        repeat (2) @(posedge clk_sys);
    endtask
    // Sample lands on the edge after the tick; alert updates on that same edge
    // A divider that never ticks counts as a mismatch
    task automatic wait_tick;
        int k;
        k = 0;
        #1;
        while (tick !== 1'b1 && k < 20) begin
            @(posedge clk_sys);
            #1;
            k++;
        end
        if (k == 20) begin
            n_errors++;
            $display("BAD %0t no sample tick", $time);
        end
    endtask
    task automatic samp(input logic [9:0] v, input logic p, input logic e);
        @(posedge clk_sys);
        adc <= v;
        pwr_ok <= p;
        wait_tick();
        @(posedge clk_sys);
        #1;
        chk({7'h00, alert}, {7'h00, e});
    endtask
    // Edges from one tick to the next must equal the divider length
    task automatic tick_gap;
        int n;
        n = 1;
        wait_tick();
        @(posedge clk_sys);
        #1;
        while (tick !== 1'b1 && n < 20) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        chk(8'(n), 8'(SIM_CYCLES));
    endtask
    task automatic give_verdict;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        #100000;
        n_errors++;
        give_verdict;
    end
    initial begin
        {sys_rst, drv, lvl, pwr_ok, behav_pin, adc} = {1'b1, 14'h0000};
        for (int i = 0; i < 3; i++) begin
            rst(i < 2, i == 1);
            rdchk(8'h33, {6'h00, exp_rng[i]});
            chk({6'h00, rng}, {6'h00, exp_rng[i]});
        end
        rdchk(8'h2E, 8'hBF);
        rdchk(8'h22, 8'hFF);
        rdchk(8'h23, 8'h03);
        rdchk(8'h30, 8'h0F);
        rdchk(8'h55, 8'h00);
        i_host.wr(8'h33, 8'hFF);
        rdchk(8'h33, 8'h0F);
        chk({6'h00, rng}, 8'h03);
        i_host.wr(8'h2E, 8'h5A);
        chk(dac, 8'h5A);
        for (int r = 0; r < 4; r++) begin
            i_host.wr(8'h30, 8'(r));
            chk({6'h00, ratio}, 8'(r));
        end
        i_host.wr(8'h00, 8'hAA);
        rdchk(8'h00, 8'h00);
        i_host.wr(8'h22, 8'h80);
        rdchk(8'h22, 8'h80);
        i_host.wr(8'h23, 8'hFC);
        rdchk(8'h23, 8'h00);
        samp(10'h201, 1'b1, 1'b1);
        rdchk(8'h00, 8'h80);
        rdchk(8'h01, 8'h01);
        tick_gap();
        samp(10'h200, 1'b1, 1'b0);
        @(posedge clk_sys);
        behav_pin <= 1'b1;
        samp(10'h3FF, 1'b1, 1'b1);
        samp(10'h3FF, 1'b0, 1'b0);
        give_verdict;
    end
endmodule // tb
